// ===== shared/tbi_pkg.sv
// constants and carrier types for the thermal and button interrupt register block
package tbi_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ     = 100_000_000;
  localparam int unsigned TICK_MS    = 1;
  localparam int unsigned TICK_CYC   = CLK_HZ / 1000 * TICK_MS;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_THERM_STAT  = 8'h20;
  localparam logic [7:0] IDX_THERM_MASK  = 8'h21;
  localparam logic [7:0] IDX_THERM_SENSE = 8'h22;
  localparam logic [7:0] IDX_BTN_STAT    = 8'h24;
  localparam logic [7:0] IDX_BTN_MASK    = 8'h25;
  localparam logic [7:0] IDX_BTN_SENSE   = 8'h26;
  localparam logic [7:0] IDX_DEB_CFG     = 8'h2c;

  // field positions
  localparam int unsigned BIT_HOT_LOW    = 0;
  localparam int unsigned BIT_HOT_HIGH   = 2;
  localparam int unsigned BIT_BTN_CHANGE = 0;
  localparam int unsigned BIT_HOLD_1     = 1;
  localparam int unsigned BIT_HOLD_2     = 2;
  localparam int unsigned BIT_HOLD_3     = 3;
  localparam int unsigned BIT_HOLD_4     = 4;
  localparam int unsigned BIT_HOLD_8     = 5;
  localparam int unsigned DEB_FALL_LSB   = 0;
  localparam int unsigned DEB_RISE_LSB   = 2;

  // implemented bits and reset values
  localparam logic [7:0] THERM_BITS     = 8'h05;
  localparam logic [7:0] BTN_BITS       = 8'h3f;
  localparam logic [7:0] DEB_CFG_BITS   = 8'h0f;
  localparam logic [7:0] THERM_MASK_RST = 8'h05;
  localparam logic [7:0] BTN_MASK_RST   = 8'h3f;
  localparam logic [7:0] DEB_CFG_RST    = 8'h00;
  localparam logic [7:0] STAT_RST       = 8'h00;

  // hold durations, in seconds, and as millisecond tick counts
  localparam int unsigned HOLD_1_S = 1;
  localparam int unsigned HOLD_2_S = 2;
  localparam int unsigned HOLD_3_S = 3;
  localparam int unsigned HOLD_4_S = 4;
  localparam int unsigned HOLD_8_S = 8;
  localparam logic [13:0] HOLD_1_TK = 14'(HOLD_1_S * 1000 / TICK_MS);
  localparam logic [13:0] HOLD_2_TK = 14'(HOLD_2_S * 1000 / TICK_MS);
  localparam logic [13:0] HOLD_3_TK = 14'(HOLD_3_S * 1000 / TICK_MS);
  localparam logic [13:0] HOLD_4_TK = 14'(HOLD_4_S * 1000 / TICK_MS);
  localparam logic [13:0] HOLD_8_TK = 14'(HOLD_8_S * 1000 / TICK_MS);

  // debounce choices in milliseconds, picked by a two-bit field
  localparam logic [7:0] DEB_SEL0_MS = 8'h10;
  localparam logic [7:0] DEB_SEL1_MS = 8'h20;
  localparam logic [7:0] DEB_SEL2_MS = 8'h40;
  localparam logic [7:0] DEB_SEL3_MS = 8'h80;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } tbi_apb_req_s;

  typedef struct packed {
    logic hot_low;
    logic hot_high;
    logic button_low;
  } tbi_pins_s;

endpackage

// ===== src/tbi_irq_regs.sv
// thermal and power-button interrupt status, mask and sense registers on apb
// Operation
// (RQ1) thermal mask bit 2 masks the 125 degree event, read-write, resets to 1.
// (RQ2) unmasked 125 degree flag pulls the interrupt line low; masked flag does not.
// (RQ3) thermal sense bit 0 reads live above-110-degree state, resets to 0.
// (RQ4) thermal sense bit 2 reads live above-125-degree state, resets to 0.
// (RQ5) button change flag bit 0 sets after press outlasts falling debounce time.
// (RQ6) change flag also sets on release outlasting rising debounce after a debounced press.
// (RQ7) status bit 1 sets once debounced press is held over one second.
// (RQ8) status bit 2 sets once debounced press is held over two seconds.
// (RQ9) status bit 3 sets once debounced press is held over three seconds.
// (RQ10) status bit 4 sets once debounced press is held over four seconds.
// (RQ11) status bit 5 sets once debounced press is held over eight seconds.
// (RQ12) button flags reset to 0 and stay set until software clears them.
// (RQ13) status flags clear on read or on writing 1; writing 0 leaves them.
// (RQ14) thermal flags set on each threshold crossing, rising or falling.
// (RQ15) button sense bit 0 follows the debounced button, 1 while pressed.
// (RQ16) hold timer starts at debounced press, restarts at release; one fire per press.
// (RQ17) unused register bits read 0 and ignore writes.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module tbi_irq_regs #(
  parameter int unsigned TICK_CYC_P = tbi_pkg::TICK_CYC
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  ce,
  input  wire tbi_pkg::tbi_apb_req_s apb_req,
  output logic                       pready,
  output logic                       pslverr,
  output logic [31:0]                prdata,
  input  wire logic                  hot_low_in,
  input  wire logic                  hot_high_in,
  input  wire logic                  power_button_in,
  input  wire logic                  irq_out_n_in,
  output logic                       irq_out_n_out,
  output logic                       irq_out_n_oe_n,
  output logic                       irq
);

  // debounce time for a select field, in millisecond ticks
  function automatic logic [7:0] deb_limit(input logic [1:0] sel);
    logic [7:0] r;
    r = tbi_pkg::DEB_SEL0_MS;
    unique case (sel)
      2'h0: r = tbi_pkg::DEB_SEL0_MS;
      2'h1: r = tbi_pkg::DEB_SEL1_MS;
      2'h2: r = tbi_pkg::DEB_SEL2_MS;
      2'h3: r = tbi_pkg::DEB_SEL3_MS;
    endcase
    return r;
  endfunction

  // one-hot register decode from a register index
  function automatic logic idx_is(input logic [7:0] idx, input logic [7:0] want);
    return idx == want;
  endfunction

  // ---------------------------------------------------------------- pins
  tbi_pkg::tbi_pins_s raw_pins;
  tbi_pkg::tbi_pins_s sync0_ff;
  tbi_pkg::tbi_pins_s sync1_ff;
  tbi_pkg::tbi_pins_s sync2_ff;
  tbi_pkg::tbi_pins_s pins_ff;

  assign raw_pins.hot_low    = hot_low_in;
  assign raw_pins.hot_high   = hot_high_in;
  assign raw_pins.button_low = ~power_button_in;

  // first stage is read by the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync0_ff <= '0;
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else if (ce) begin
      sync0_ff <= raw_pins;
      sync1_ff <= sync0_ff;
      sync2_ff <= sync1_ff;
    end
  end

  // a change counts once the second and third stages agree
  tbi_pkg::tbi_pins_s nxt_pins;
  always_comb begin
    nxt_pins = pins_ff;
    if (sync1_ff.hot_low == sync2_ff.hot_low) begin
      nxt_pins.hot_low = sync2_ff.hot_low;
    end
    if (sync1_ff.hot_high == sync2_ff.hot_high) begin
      nxt_pins.hot_high = sync2_ff.hot_high;
    end
    if (sync1_ff.button_low == sync2_ff.button_low) begin
      nxt_pins.button_low = sync2_ff.button_low;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_ff <= '0;
    end else if (ce) begin
      pins_ff <= nxt_pins; // [RQ3] [RQ4]
    end
  end

  // ---------------------------------------------------------------- time base
  logic [16:0] tick_cnt_ff;
  logic        tick;

  assign tick = (tick_cnt_ff == 17'(TICK_CYC_P - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_ff <= 17'h0;
    end else if (ce) begin
      tick_cnt_ff <= tick ? 17'h0 : tick_cnt_ff + 17'h1;
    end
  end

  // ---------------------------------------------------------------- registers
  logic [7:0] therm_stat_ff;
  logic [7:0] therm_mask_ff;
  logic [7:0] btn_stat_ff;
  logic [7:0] btn_mask_ff;
  logic [7:0] deb_cfg_ff;

  // ---------------------------------------------------------------- debounce
  logic       pressed_ff;
  logic [7:0] deb_cnt_ff;
  logic [7:0] deb_lim;
  logic       deb_flip;

  // limit depends on the direction the debounced state would move
  assign deb_lim  = pressed_ff ? deb_limit(deb_cfg_ff[tbi_pkg::DEB_RISE_LSB +: 2])
                               : deb_limit(deb_cfg_ff[tbi_pkg::DEB_FALL_LSB +: 2]);
  assign deb_flip = (pins_ff.button_low != pressed_ff) && tick && (deb_cnt_ff == deb_lim - 8'h1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cnt_ff <= 8'h0;
    end else if (ce) begin
      // any bounce back to the settled level restarts the wait
      if (pins_ff.button_low == pressed_ff || deb_flip) begin
        deb_cnt_ff <= 8'h0;
      end else if (tick) begin
        deb_cnt_ff <= deb_cnt_ff + 8'h1;
      end
    end
  end

  // release can only flip a state that a full press debounce set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pressed_ff <= 1'b0;
    end else if (ce && deb_flip) begin
      pressed_ff <= ~pressed_ff; // [RQ15] [RQ6]
    end
  end

  // ---------------------------------------------------------------- hold timer
  logic [13:0] hold_cnt_ff;
  logic [4:0]  hold_hit;
  logic [4:0]  hold_live;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_ff <= 14'h0;
    end else if (ce) begin
      if (!pressed_ff) begin
        hold_cnt_ff <= 14'h0; // [RQ16]
      end else if (tick && hold_cnt_ff != tbi_pkg::HOLD_8_TK) begin
        // saturates so each duration fires once per press
        hold_cnt_ff <= hold_cnt_ff + 14'h1; // [RQ16]
      end
    end
  end

  // a duration is passed on the tick that reaches its count
  assign hold_hit[0] = pressed_ff && tick && hold_cnt_ff == tbi_pkg::HOLD_1_TK - 14'h1; // [RQ7]
  assign hold_hit[1] = pressed_ff && tick && hold_cnt_ff == tbi_pkg::HOLD_2_TK - 14'h1; // [RQ8]
  assign hold_hit[2] = pressed_ff && tick && hold_cnt_ff == tbi_pkg::HOLD_3_TK - 14'h1; // [RQ9]
  assign hold_hit[3] = pressed_ff && tick && hold_cnt_ff == tbi_pkg::HOLD_4_TK - 14'h1; // [RQ10]
  assign hold_hit[4] = pressed_ff && tick && hold_cnt_ff == tbi_pkg::HOLD_8_TK - 14'h1; // [RQ11]

  assign hold_live[0] = pressed_ff && hold_cnt_ff >= tbi_pkg::HOLD_1_TK;
  assign hold_live[1] = pressed_ff && hold_cnt_ff >= tbi_pkg::HOLD_2_TK;
  assign hold_live[2] = pressed_ff && hold_cnt_ff >= tbi_pkg::HOLD_3_TK;
  assign hold_live[3] = pressed_ff && hold_cnt_ff >= tbi_pkg::HOLD_4_TK;
  assign hold_live[4] = pressed_ff && hold_cnt_ff >= tbi_pkg::HOLD_8_TK;

  // ---------------------------------------------------------------- apb decode
  logic       load;
  logic       held_ff;
  logic       done;
  logic       wr_done;
  logic       rd_done;
  logic [7:0] idx;
  logic       mapped;
  logic [7:0] rd_mux;
  logic [7:0] wdata;
  logic [7:0] prdata_ff;

  // data taken on the first enabled edge of a transfer; a setup cycle lost to a
  // freeze costs a read one wait state instead of returning stale data
  assign load    = apb_req.psel && ce && !held_ff;
  // a frozen block holds the master in its access phase
  assign pready  = ce && (apb_req.pwrite || held_ff);
  assign done    = apb_req.psel && apb_req.penable && pready;
  assign wr_done = done && apb_req.pwrite && mapped;
  assign rd_done = done && !apb_req.pwrite && mapped;
  assign idx     = apb_req.paddr[9:2];
  assign wdata   = apb_req.pwdata[7:0];
  assign mapped  = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr[11:10] == 2'h0) &&
                   (idx_is(idx, tbi_pkg::IDX_THERM_STAT) || idx_is(idx, tbi_pkg::IDX_THERM_MASK) ||
                    idx_is(idx, tbi_pkg::IDX_THERM_SENSE) || idx_is(idx, tbi_pkg::IDX_BTN_STAT) ||
                    idx_is(idx, tbi_pkg::IDX_BTN_MASK) || idx_is(idx, tbi_pkg::IDX_BTN_SENSE) ||
                    idx_is(idx, tbi_pkg::IDX_DEB_CFG));
  assign pslverr = done && !mapped;
  assign prdata  = {24'h0, prdata_ff};

  always_comb begin
    rd_mux = 8'h0;
    if (mapped) begin
      unique case (idx)
        tbi_pkg::IDX_THERM_STAT:  rd_mux = therm_stat_ff;
        tbi_pkg::IDX_THERM_MASK:  rd_mux = therm_mask_ff;
        tbi_pkg::IDX_THERM_SENSE: begin
          rd_mux[tbi_pkg::BIT_HOT_LOW]  = pins_ff.hot_low;  // [RQ3]
          rd_mux[tbi_pkg::BIT_HOT_HIGH] = pins_ff.hot_high; // [RQ4]
        end
        tbi_pkg::IDX_BTN_STAT:    rd_mux = btn_stat_ff;
        tbi_pkg::IDX_BTN_MASK:    rd_mux = btn_mask_ff;
        tbi_pkg::IDX_BTN_SENSE:   rd_mux = {2'h0, hold_live, pressed_ff}; // [RQ15]
        tbi_pkg::IDX_DEB_CFG:     rd_mux = deb_cfg_ff;
        default:                  rd_mux = 8'h0; // [RQ17]
      endcase
    end
  end

  // marks that this transfer has its data; completion wins over a new capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_ff <= 1'b0;
    end else if (done) begin
      held_ff <= 1'b0;
    end else if (load) begin
      held_ff <= 1'b1;
    end
  end

  // read data is captured once per transfer and answered in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 8'h0;
    end else if (load) begin
      prdata_ff <= apb_req.pwrite ? 8'h0 : rd_mux;
    end
  end

  // ---------------------------------------------------------------- mask and config
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_mask_ff <= tbi_pkg::THERM_MASK_RST; // [RQ1]
    end else if (wr_done && idx == tbi_pkg::IDX_THERM_MASK) begin
      therm_mask_ff <= wdata & tbi_pkg::THERM_BITS; // [RQ1] [RQ17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_mask_ff <= tbi_pkg::BTN_MASK_RST;
    end else if (wr_done && idx == tbi_pkg::IDX_BTN_MASK) begin
      btn_mask_ff <= wdata & tbi_pkg::BTN_BITS; // [RQ17]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_cfg_ff <= tbi_pkg::DEB_CFG_RST;
    end else if (wr_done && idx == tbi_pkg::IDX_DEB_CFG) begin
      deb_cfg_ff <= wdata & tbi_pkg::DEB_CFG_BITS; // [RQ17]
    end
  end

  // ---------------------------------------------------------------- sticky status
  logic [7:0] therm_set;
  logic [7:0] therm_clr;
  logic [7:0] btn_set;
  logic [7:0] btn_clr;

  always_comb begin
    therm_set = 8'h0;
    therm_set[tbi_pkg::BIT_HOT_LOW]  = nxt_pins.hot_low != pins_ff.hot_low;   // [RQ14]
    therm_set[tbi_pkg::BIT_HOT_HIGH] = nxt_pins.hot_high != pins_ff.hot_high; // [RQ14]
    btn_set = 8'h0;
    btn_set[tbi_pkg::BIT_BTN_CHANGE] = deb_flip; // [RQ5] [RQ6]
    btn_set[tbi_pkg::BIT_HOLD_1]     = hold_hit[0];
    btn_set[tbi_pkg::BIT_HOLD_2]     = hold_hit[1];
    btn_set[tbi_pkg::BIT_HOLD_3]     = hold_hit[2];
    btn_set[tbi_pkg::BIT_HOLD_4]     = hold_hit[3];
    btn_set[tbi_pkg::BIT_HOLD_8]     = hold_hit[4];
  end

  // a read clears only the bits it returned, so a later event is not lost
  always_comb begin
    therm_clr = 8'h0;
    btn_clr   = 8'h0;
    if (idx == tbi_pkg::IDX_THERM_STAT) begin
      if (rd_done) begin
        therm_clr = prdata_ff; // [RQ13]
      end else if (wr_done) begin
        therm_clr = wdata; // [RQ13]
      end
    end
    if (idx == tbi_pkg::IDX_BTN_STAT) begin
      if (rd_done) begin
        btn_clr = prdata_ff; // [RQ13]
      end else if (wr_done) begin
        btn_clr = wdata; // [RQ13]
      end
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      therm_stat_ff <= tbi_pkg::STAT_RST;
    end else if (ce) begin
      therm_stat_ff <= ((therm_stat_ff & ~therm_clr) | therm_set) & tbi_pkg::THERM_BITS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_stat_ff <= tbi_pkg::STAT_RST; // [RQ12]
    end else if (ce) begin
      btn_stat_ff <= ((btn_stat_ff & ~btn_clr) | btn_set) & tbi_pkg::BTN_BITS; // [RQ12]
    end
  end

  // ---------------------------------------------------------------- interrupt line
  // open drain: the pin only ever drives low, its own level is not needed here
  assign irq            = |(therm_stat_ff & ~therm_mask_ff) |
                          |(btn_stat_ff & ~btn_mask_ff); // [RQ2]
  assign irq_out_n_out  = 1'b0;
  assign irq_out_n_oe_n = ~irq; // [RQ2]

endmodule

`default_nettype wire

// ===== testbench/tbi_irq_regs_monitor.sv
// concurrent checks on the ports of the interrupt register block
`timescale 1ns/1ns
`default_nettype none
module tbi_irq_regs_monitor #(
  parameter int unsigned TICK_CYC_P = 4
) (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire logic                  ce,
  input wire tbi_pkg::tbi_apb_req_s apb_req,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic [31:0]           prdata,
  input wire logic                  hot_low_in,
  input wire logic                  hot_high_in,
  input wire logic                  power_button_in,
  input wire logic                  irq_out_n_in,
  input wire logic                  irq_out_n_out,
  input wire logic                  irq_out_n_oe_n,
  input wire logic                  irq
);
  logic       acc;
  logic       rd;
  logic       map;
  logic [1:0] hot_prev_ff;
  logic [3:0] stab_ff;
  assign acc = apb_req.psel & apb_req.penable & pready;
  assign rd  = acc & ~apb_req.pwrite;
  assign map = apb_req.paddr inside {12'h080, 12'h084, 12'h088, 12'h090, 12'h094, 12'h098,
                                     12'h0b0};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // comparator inputs still for a while, so the synchroniser has caught up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hot_prev_ff <= 2'b00;
      stab_ff     <= 4'h0;
    end else begin
      hot_prev_ff <= {hot_high_in, hot_low_in};
      if (hot_prev_ff != {hot_high_in, hot_low_in} || !ce) stab_ff <= 4'h0;
      else if (stab_ff != 4'hf) stab_ff <= stab_ff + 4'h1;
    end
  end
  a_pin_follows_irq: assert property (
    irq_out_n_oe_n == !irq && irq_out_n_out == 1'b0) else $error("pin drive differs from irq");
  a_masked_after_reset: assert property (
    $rose(presetn) |-> !irq [*2]) else $error("irq raised right after reset");
  a_unmapped_error: assert property (
    acc && !map |-> pslverr) else $error("unmapped access without error");
  a_error_when_unmapped: assert property (
    pslverr |-> acc && !map) else $error("error outside unmapped access");
  a_unmapped_reads_zero: assert property (
    rd && !map |-> prdata == 32'h0) else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (
    rd |-> prdata[31:8] == 24'h0) else $error("upper read bits not zero");
  a_therm_unused_zero: assert property (
    rd && apb_req.paddr inside {12'h080, 12'h084, 12'h088} |-> (prdata[7:0] & 8'hfa) == 8'h0)
    else $error("unused thermal bits set");
  a_btn_unused_zero: assert property (
    rd && apb_req.paddr inside {12'h090, 12'h094, 12'h098} |-> prdata[7:6] == 2'b00)
    else $error("unused button bits set");
  a_sense_live: assert property (
    rd && apb_req.paddr == 12'h088 && stab_ff >= 4'h8
    |-> prdata[7:0] == {5'h0, hot_high_in, 1'b0, hot_low_in}) else $error("sense not live");
  c_irq_raised: cover property ($rose(irq));
  c_unmapped: cover property (pslverr);
  c_btn_flag_read: cover property (rd && apb_req.paddr == 12'h090 && prdata[7:0] != 8'h0);
endmodule
bind tbi_irq_regs tbi_irq_regs_monitor #(.TICK_CYC_P(TICK_CYC_P)) tbi_irq_regs_monitor_inst (
  .pclk(pclk), .presetn(presetn), .ce(ce), .apb_req(apb_req), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .hot_low_in(hot_low_in), .hot_high_in(hot_high_in),
  .power_button_in(power_button_in), .irq_out_n_in(irq_out_n_in),
  .irq_out_n_out(irq_out_n_out), .irq_out_n_oe_n(irq_out_n_oe_n), .irq(irq));
`default_nettype wire

// ===== testbench/tbi_host_model.sv
// host side of the open-drain interrupt line with its pull-up
`timescale 1ns/1ns
`default_nettype none
module tbi_host_model (
  input  wire logic irq_out_n_out,
  input  wire logic irq_out_n_oe_n,
  output logic      irq_line
);
  // released pin goes to the pull-up level, never the last driven value
  assign irq_line = irq_out_n_oe_n ? 1'b1 : irq_out_n_out;
endmodule
`default_nettype wire

// ===== testbench/test_thermal_button_interrupt_regs.sv
// self-checking bench for the thermal and button interrupt register block
`timescale 1ns/1ns
`default_nettype none
module test_thermal_button_interrupt_regs;
  localparam int          TK   = 4;
  localparam logic [11:0] A_TS = 12'h080;
  localparam logic [11:0] A_TM = 12'h084;
  localparam logic [11:0] A_SE = 12'h088;
  localparam logic [11:0] A_BS = 12'h090;
  localparam logic [11:0] A_BM = 12'h094;
  localparam logic [11:0] A_BN = 12'h098;
  localparam logic [11:0] A_DB = 12'h0b0;
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  ce = 1'b1;
  int                    wait_n = 0;
  tbi_pkg::tbi_apb_req_s req = '0;
  logic                  hot_lo = 1'b0;
  logic                  hot_hi = 1'b0;
  logic                  btn = 1'b1;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  logic                  oe_n;
  logic                  od_out;
  logic                  pin;
  logic [31:0]           prdata;
  logic [31:0]           rdata_q;
  logic                  err_q;
  int                    num_errors = 0;
  int                    samples_checked = 0;
  always #5 pclk = ~pclk;
  tbi_irq_regs #(.TICK_CYC_P(TK)) tbi_irq_regs_inst (.pclk(pclk), .presetn(presetn),
    .ce(ce), .apb_req(req), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .hot_low_in(hot_lo), .hot_high_in(hot_hi), .power_button_in(btn), .irq_out_n_in(pin),
    .irq_out_n_out(od_out), .irq_out_n_oe_n(oe_n), .irq(irq));
  tbi_host_model tbi_host_model_inst (.irq_out_n_out(od_out), .irq_out_n_oe_n(oe_n),
    .irq_line(pin));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk) req <= '{1'b1, 1'b0, w, a, {24'h0, d}};
    @(posedge pclk) req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdata_q = prdata;
    err_q = pslverr;
    wait_n = n;
    req <= '0;
    if (n >= 20) begin
      num_errors++;
      end_sim();
    end
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    apb(a, 1'b0, 8'h00);
    chk($sformatf("reg %h", a), {24'h0, e}, rdata_q);
  endtask
  task automatic pin_chk(input logic e);
    @(negedge pclk);
    chk("irq line", {31'h0, e}, {31'h0, pin});
    @(posedge pclk);
  endtask
  task automatic wait_tk(input int n);
    repeat (n * TK) @(posedge pclk);
  endtask
  function automatic int deb(input int sel);
    return 16 << (sel & 3);
  endfunction
  function automatic logic [7:0] hold_sense(input int i);
    return 8'((16'h4 << i) - 16'h1);
  endfunction
  // hang guard well beyond the longest hold sequence
  initial begin
    #1_000_000;
    num_errors++;
    end_sim();
  end
  initial begin
    logic [11:0] ra[7];
    logic [7:0]  rv[7];
    int          hs[5];
    int          sel;
    longint      t0;
    ra = '{A_TS, A_TM, A_SE, A_BS, A_BM, A_BN, A_DB};
    rv = '{8'h00, 8'h05, 8'h00, 8'h00, 8'h3f, 8'h00, 8'h00};
    hs = '{1, 2, 3, 4, 8};
    void'($urandom(32'h748b8837));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
    apb(12'h08c, 1'b0, 8'h00);
    chk("slverr", 32'h1, {31'h0, err_q});
    apb(A_SE, 1'b1, 8'hff);
    rd_chk(A_SE, 8'h00);
    repeat (6) begin
      sel = $urandom;
      apb(A_TM, 1'b1, 8'(sel));
      rd_chk(A_TM, 8'(sel) & 8'h05);
    end
    // freeze across a whole setup cycle: the read must still return fresh data
    ce <= 1'b0;
    fork
      rd_chk(A_TM, 8'(sel) & 8'h05);
      begin
        repeat (5) @(posedge pclk);
        ce <= 1'b1;
      end
    join
    chk("wait states", 32'h5, wait_n);
    apb(A_TM, 1'b1, 8'h01);
    hot_hi <= 1'b1;
    repeat (10) @(posedge pclk);
    rd_chk(A_SE, 8'h04);
    pin_chk(1'b0);
    rd_chk(A_TS, 8'h04);
    pin_chk(1'b1);
    hot_hi <= 1'b0;
    hot_lo <= 1'b1;
    repeat (10) @(posedge pclk);
    pin_chk(1'b0);
    apb(A_TS, 1'b1, 8'h00);
    pin_chk(1'b0);
    apb(A_TS, 1'b1, 8'h04);
    pin_chk(1'b1);
    apb(A_TM, 1'b1, 8'h04);
    pin_chk(1'b0);
    rd_chk(A_SE, 8'h01);
    rd_chk(A_TS, 8'h01);
    sel = $urandom_range(15);
    apb(A_DB, 1'b1, 8'(sel));
    btn <= 1'b0;
    wait_tk($urandom_range(12, 2));
    btn <= 1'b1;
    wait_tk(40);
    rd_chk(A_BS, 8'h00);
    t0 = $time;
    btn <= 1'b0;
    wait_tk(deb(sel) + 8);
    rd_chk(A_BN, 8'h01);
    apb(A_BM, 1'b1, 8'h3e);
    pin_chk(1'b0);
    rd_chk(A_BS, 8'h01);
    pin_chk(1'b1);
    for (int i = 0; i < 5; i++) begin
      while ($time < t0 + (deb(sel) + 1000 * hs[i] - 10) * TK * 10) @(posedge pclk);
      rd_chk(A_BS, 8'h00);
      while ($time < t0 + (deb(sel) + 1000 * hs[i] + 10) * TK * 10) @(posedge pclk);
      rd_chk(A_BS, 8'(8'h02 << i));
      rd_chk(A_BN, hold_sense(i));
    end
    btn <= 1'b1;
    wait_tk(deb(sel >> 2) + 8);
    rd_chk(A_BN, 8'h00);
    wait_tk(1000);
    rd_chk(A_BS, 8'h01);
    rd_chk(A_BS, 8'h00);
    presetn <= 1'b0;
    @(posedge pclk) presetn <= 1'b1;
    rd_chk(A_TM, 8'h05);
    end_sim();
  end
endmodule
`default_nettype wire
